// ---- hdl/eoc_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Pulse position: count on trigger rising edge
// - Time base ignored while pulse counting
// - A-to-B mode counts module transitions
// - Group 1 start-A match enters group 2
// - Group 2 start-B match emits trigger
// - Group 2 end-A traces, back to group 1
// - A-to-B traces only on exit event
// - Comparators match inclusive address range
// - Range mode triggers on each comparator one match
// - Range mode traces every bus cycle
// - Entry holds address, data, direction, count
// - Sequencer evaluates once per bus cycle
module eoc_counter
   import eoc_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // Target bus cycle
   input  wire logic               bus_cycle,
   input  wire logic [ADDR_W-1:0]  bus_addr,
   input  wire logic [DATA_W-1:0]  bus_data,
   input  wire logic               bus_read,
   // Manual reset button
   input  wire logic               manual_clear,
   // Register port
   input  wire logic [3:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // Observation outputs
   output logic                    event_trigger_pulse,
   output logic                    trace_capture_action,
   output logic                    group_switch_action,
   output logic      [COUNT_W-1:0] count_value
);

   logic [31:0]         ctrl_reg;
   logic [ADDR_W-1:0]   bnd_reg [0:5];
   logic [COUNT_W-1:0]  count_reg;
   logic [COUNT_W-1:0]  count_next;
   eoc_grp_t            grp_reg;
   logic                trig_prev_reg;
   logic                trig_next;
   logic                trace_next;
   logic                gsw_next;
   logic [ENTRY_W-1:0]  trace_mem [0:TRACE_DEPTH-1];
   logic [TRACE_AW-1:0] wr_ptr_reg;
   logic [TRACE_AW-1:0] tr_sel_reg;
   logic                wrapped_reg;
   logic [ENTRY_W-1:0]  sel_entry;
   logic                address_comparator_one;
   logic                address_comparator_two;
   logic                ac1_g1;
   logic                ac1_g2;
   logic [31:0]         rdata_next;

   function automatic logic [31:0] pad_addr(input logic [ADDR_W-1:0] a);
      pad_addr = {{(32-ADDR_W){1'b0}}, a};
   endfunction : pad_addr

   eoc_range_cmp u_ac1_g1 (
      .lo_bound  (bnd_reg[0]),
      .hi_bound  (bnd_reg[1]),
      .bus_addr  (bus_addr),
      .bus_valid (bus_cycle),
      .match     (ac1_g1)
   );
   eoc_range_cmp u_ac1_g2 (
      .lo_bound  (bnd_reg[2]),
      .hi_bound  (bnd_reg[3]),
      .bus_addr  (bus_addr),
      .bus_valid (bus_cycle),
      .match     (ac1_g2)
   );
   eoc_range_cmp u_ac2_g2 (
      .lo_bound  (bnd_reg[4]),
      .hi_bound  (bnd_reg[5]),
      .bus_addr  (bus_addr),
      .bus_valid (bus_cycle),
      .match     (address_comparator_two)
   );

   // Comparator one is banked by event group
   always_comb begin
      address_comparator_one = (grp_reg == EOC_GRP2) ? ac1_g2 : ac1_g1;
   end

   wire logic mode_range = ctrl_reg[CTRL_MODE_BIT];
   wire logic pulse_pos  = ctrl_reg[CTRL_TB_LSB +: CTRL_TB_W] == SW_PULSE_COUNT;

   // Control register and bounds
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_reg <= reg_wdata & ~(32'h1 << CTRL_CLR_BIT);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 6; i++) begin
            bnd_reg[i] <= '0;
         end
      end else if (reg_wr && reg_addr >= REG_AC1G1_LO && reg_addr <= REG_AC2G2_HI) begin
         bnd_reg[3'(reg_addr - REG_AC1G1_LO)] <= reg_wdata[ADDR_W-1:0];
      end
   end

   // Sequencer actions, decided only on a bus cycle
   always_comb begin
      trig_next  = 1'b0;
      trace_next = 1'b0;
      gsw_next   = 1'b0;
      if (bus_cycle) begin
         if (mode_range) begin
            trig_next  = address_comparator_one;
            trace_next = 1'b1;
         end else begin
            case (grp_reg)
               EOC_GRP1: begin
                  gsw_next = address_comparator_one;
               end
               EOC_GRP2: begin
                  trig_next  = address_comparator_one;
                  trace_next = address_comparator_two;
                  gsw_next   = address_comparator_two;
               end
               default: begin
                  gsw_next = 1'b0;
               end
            endcase
         end
      end
   end

   // Event group state
   always_ff @(posedge clk) begin
      if (sys_rst || mode_range) begin
         grp_reg <= EOC_GRP1;
      end else if (gsw_next) begin
         grp_reg <= (grp_reg == EOC_GRP1) ? EOC_GRP2 : EOC_GRP1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         event_trigger_pulse  <= 1'b0;
         trace_capture_action <= 1'b0;
         group_switch_action  <= 1'b0;
         trig_prev_reg        <= 1'b0;
      end else begin
         event_trigger_pulse  <= trig_next;
         trace_capture_action <= trace_next;
         group_switch_action  <= gsw_next;
         trig_prev_reg        <= event_trigger_pulse;
      end
   end

   // Count advances same edge as trigger so trace sees updated value
   always_comb begin
      count_next = count_reg;
      if (pulse_pos && trig_next && !event_trigger_pulse) begin
         count_next = count_reg + COUNT_ONE;
      end else if (pulse_pos && trig_next && !trig_prev_reg && event_trigger_pulse) begin
         count_next = count_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || manual_clear ||
          (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_BIT])) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_value <= '0;
      end else begin
         count_value <= count_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (trace_next) begin
         trace_mem[wr_ptr_reg] <= {bus_addr, bus_data, bus_read, count_next};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_reg  <= '0;
         wrapped_reg <= 1'b0;
      end else if (trace_next) begin
         wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
         if (&wr_ptr_reg) begin
            wrapped_reg <= 1'b1;
         end
      end
   end

   // Select counts back from newest: 0 is most recent
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tr_sel_reg <= '0;
      end else if (reg_wr && reg_addr == REG_TR_SEL) begin
         tr_sel_reg <= reg_wdata[TRACE_AW-1:0];
      end
   end

   always_comb begin
      sel_entry = trace_mem[wr_ptr_reg - PTR_ONE - tr_sel_reg];
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      case (reg_addr)
         REG_CTRL:     rdata_next = ctrl_reg;
         REG_AC1G1_LO: rdata_next = pad_addr(bnd_reg[0]);
         REG_AC1G1_HI: rdata_next = pad_addr(bnd_reg[1]);
         REG_AC1G2_LO: rdata_next = pad_addr(bnd_reg[2]);
         REG_AC1G2_HI: rdata_next = pad_addr(bnd_reg[3]);
         REG_AC2G2_LO: rdata_next = pad_addr(bnd_reg[4]);
         REG_AC2G2_HI: rdata_next = pad_addr(bnd_reg[5]);
         REG_COUNT:    rdata_next = {16'h0000, count_reg};
         REG_STATUS:   rdata_next = {22'h0, wrapped_reg, wr_ptr_reg,
                                     grp_reg == EOC_GRP2, 2'h0};
         REG_TR_SEL:   rdata_next = {26'h0, tr_sel_reg};
         REG_TR_ADDR:  rdata_next = pad_addr(sel_entry[ENTRY_W-1 -: ADDR_W]);
         REG_TR_DATA:  rdata_next = {15'h0, sel_entry[COUNT_W], 
                                     sel_entry[COUNT_W+1 +: DATA_W]};
         REG_TR_COUNT: rdata_next = {16'h0000, sel_entry[COUNT_W-1:0]};
         default:      rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule : eoc_counter
`default_nettype wire

// ---- hdl/eoc_pkg.sv ----
package eoc_pkg;

   // Target bus and counter widths
   localparam int ADDR_W  = 24;
   localparam int DATA_W  = 16;
   localparam int COUNT_W = 16;

   // Trace memory
   localparam int TRACE_DEPTH = 64;
   localparam int TRACE_AW    = 6;
   localparam int ENTRY_W     = ADDR_W + DATA_W + 1 + COUNT_W;

   // Register indices
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_AC1G1_LO = 4'h1;
   localparam logic [3:0] REG_AC1G1_HI = 4'h2;
   localparam logic [3:0] REG_AC1G2_LO = 4'h3;
   localparam logic [3:0] REG_AC1G2_HI = 4'h4;
   localparam logic [3:0] REG_AC2G2_LO = 4'h5;
   localparam logic [3:0] REG_AC2G2_HI = 4'h6;
   localparam logic [3:0] REG_COUNT    = 4'h7;
   localparam logic [3:0] REG_STATUS   = 4'h8;
   localparam logic [3:0] REG_TR_SEL   = 4'h9;
   localparam logic [3:0] REG_TR_ADDR  = 4'hA;
   localparam logic [3:0] REG_TR_DATA  = 4'hB;
   localparam logic [3:0] REG_TR_COUNT = 4'hC;

   // Control fields
   localparam int CTRL_MODE_BIT  = 0;
   localparam int CTRL_PULSE_BIT = 1;
   localparam int CTRL_CLR_BIT   = 2;
   localparam int CTRL_TB_LSB    = 4;
   localparam int CTRL_TB_W      = 4;

   // Mode switch position that counts trigger pulses
   localparam logic [3:0] SW_PULSE_COUNT = 4'hF;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_00F2;

   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam logic [TRACE_AW-1:0] PTR_ONE  = 6'h01;

   typedef enum logic [1:0] {
      EOC_MODE_AB    = 2'h0,
      EOC_MODE_RANGE = 2'h1
   } eoc_mode_t;

   // Gray coded: group1 <-> group2 is a single-bit change
   typedef enum logic [1:0] {
      EOC_GRP1 = 2'b00,
      EOC_GRP2 = 2'b01
   } eoc_grp_t;

endpackage : eoc_pkg

// ---- hdl/eoc_range_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module eoc_range_cmp
   import eoc_pkg::*;
(
   // Bounds
   input  wire logic [ADDR_W-1:0] lo_bound,
   input  wire logic [ADDR_W-1:0] hi_bound,
   // Bus address
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic              bus_valid,
   output var  logic              match
);
   always_comb begin
      match = bus_valid && (bus_addr >= lo_bound) && (bus_addr <= hi_bound);
   end
endmodule : eoc_range_cmp
`default_nettype wire

// ---- bench/eoc_counter_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module eoc_chk
   import eoc_pkg::*;
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               sys_rst,
   // Stimulus side
   input wire logic               bus_cycle,
   input wire logic               manual_clear,
   input wire logic [3:0]         reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   // Observed outputs
   input wire logic               event_trigger_pulse,
   input wire logic               trace_capture_action,
   input wire logic               group_switch_action,
   input wire logic [COUNT_W-1:0] count_value
);
   logic sw_f;
   logic rng;
   // Software clear through the control word
   wire logic clr_wr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_BIT];

   // Shadow of switch and mode, so checks know the setup
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sw_f <= 1'b1;
         rng  <= 1'b0;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         sw_f <= reg_wdata[7:4] == SW_PULSE_COUNT;
         rng  <= reg_wdata[CTRL_MODE_BIT];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_trig_after_bus: assert property (event_trigger_pulse |-> $past(bus_cycle))
      else $error("trigger without bus cycle");
   a_trace_after_bus: assert property (trace_capture_action |-> $past(bus_cycle))
      else $error("trace without bus cycle");
   a_group_after_bus: assert property (group_switch_action |-> $past(bus_cycle))
      else $error("group switch without bus cycle");
   a_count_step: assert property (!$stable(count_value) |->
      count_value == $past(count_value) + COUNT_ONE || count_value == '0)
      else $error("count moved by other than one");
   a_count_follows: assert property ($rose(event_trigger_pulse) && sw_f &&
      !manual_clear && !$past(manual_clear) && !clr_wr && !$past(clr_wr)
      |=> count_value == $past(count_value) + COUNT_ONE)
      else $error("trigger did not add one");
   a_count_frozen: assert property (!$past(sw_f) && !$past(sw_f, 2) &&
      !$past(manual_clear, 2) && !$past(clr_wr, 2) |-> $stable(count_value))
      else $error("count moved off pulse position");
   a_ab_trace_exit: assert property (trace_capture_action && !$past(rng) |->
      group_switch_action)
      else $error("transition trace without return to group one");
   a_clear_zero: assert property ((manual_clear && !bus_cycle)[*3] |=> count_value == '0)
      else $error("manual clear left count");
   a_range_trace: assert property (rng && bus_cycle |=> trace_capture_action)
      else $error("range cycle not traced");

   c_trigger: cover property (event_trigger_pulse);
   c_ab_trace: cover property (trace_capture_action && !rng);
   c_group: cover property (group_switch_action);
endmodule : eoc_chk

bind eoc_counter eoc_chk u_eoc_chk (
   .clk(clk), .sys_rst(sys_rst), .bus_cycle(bus_cycle), .manual_clear(manual_clear),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .event_trigger_pulse(event_trigger_pulse), .trace_capture_action(trace_capture_action),
   .group_switch_action(group_switch_action), .count_value(count_value)
);
`default_nettype wire

// ---- bench/eoc_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eoc_bus_model
   import eoc_pkg::*;
(
   // Clock and request
   input wire logic              clk,
   input wire logic              go,
   input wire logic [ADDR_W-1:0] a,
   input wire logic [DATA_W-1:0] d,
   input wire logic              r,
   // Target bus
   output var logic              bus_cycle,
   output var logic [ADDR_W-1:0] bus_addr,
   output var logic [DATA_W-1:0] bus_data,
   output var logic              bus_read
);
   initial {bus_cycle, bus_addr, bus_data, bus_read} = '0;
   // Idle lines flip, so stale values never look valid
   always @(posedge clk) begin
      bus_cycle <= go;
      bus_addr  <= go ? a : ~bus_addr;
      bus_data  <= go ? d : ~bus_data;
      bus_read  <= go ? r : ~bus_read;
   end
endmodule : eoc_bus_model
`default_nettype wire

// ---- bench/test_event_occurrence_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_event_occurrence_counter
   import eoc_pkg::*;
();
   typedef struct {
      logic [ADDR_W-1:0]  a;
      logic [2:0]         act;
      logic [COUNT_W-1:0] n;
   } eoc_row_t;
   logic               clk, sys_rst, go, manual_clear, reg_wr, reg_rd;
   logic               bus_cycle, bus_read, trig, trace, grp;
   logic [ADDR_W-1:0]  a, bus_addr;
   logic [DATA_W-1:0]  bus_data;
   logic [3:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata;
   logic [COUNT_W-1:0] count_value;
   int                 n_mismatch = 0;
   int                 n_checks = 0;
   int                 cyc = 0;
   // Actions as {trigger, trace, group switch}
   eoc_row_t rows [9] = '{'{24'h002000, 3'h0, 16'h0}, '{24'h001000, 3'h1, 16'h0},
      '{24'h002000, 3'h4, 16'h1}, '{24'h001100, 3'h3, 16'h1}, '{24'h002000, 3'h0, 16'h1},
      '{24'h001010, 3'h1, 16'h1}, '{24'h002001, 3'h0, 16'h1}, '{24'h002000, 3'h4, 16'h2},
      '{24'h001100, 3'h3, 16'h2}};

   eoc_bus_model u_eoc_bus_model (
      .clk(clk), .go(go), .a(a), .d(a[DATA_W-1:0]), .r(~a[0]), .bus_cycle(bus_cycle),
      .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read));
   eoc_counter u_eoc_counter (
      .clk(clk), .sys_rst(sys_rst), .bus_cycle(bus_cycle), .bus_addr(bus_addr),
      .bus_data(bus_data), .bus_read(bus_read), .manual_clear(manual_clear),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .event_trigger_pulse(trig), .trace_capture_action(trace),
      .group_switch_action(grp), .count_value(count_value));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", s, e, g);
         n_mismatch++;
      end
   endtask : chk

   task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
      @(posedge clk);
      reg_addr  <= ad;
      reg_wdata <= wd;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] ad, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk("read data", e, reg_rdata);
   endtask : rd

   // Action 7 skips the trigger, trace and group switch check
   task automatic bus(input logic [ADDR_W-1:0] ad, input logic [2:0] act,
                      input logic [COUNT_W-1:0] n);
      @(posedge clk);
      a  <= ad;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1 if (act !== 3'h7) chk("actions", {29'h0, act}, {29'h0, trig, trace, grp});
      @(posedge clk);
      #1 chk("count", {16'h0, n}, {16'h0, count_value});
   endtask : bus

   task automatic clr;
      @(posedge clk);
      manual_clear <= 1'b1;
      repeat (3) @(posedge clk);
      manual_clear <= 1'b0;
   endtask : clr

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // Whole run needs about 140 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end

   initial begin
      {sys_rst, go, manual_clear, reg_wr, reg_rd} = 5'h10;
      a = '0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_COUNT, 32'h0);
      rd(4'hF, 32'h0);
      $display("reset test done");
      wr(REG_AC1G1_LO, 32'h1000);
      wr(REG_AC1G1_HI, 32'h1010);
      wr(REG_AC1G2_LO, 32'h2000);
      wr(REG_AC1G2_HI, 32'h2000);
      wr(REG_AC2G2_LO, 32'h1100);
      wr(REG_AC2G2_HI, 32'h1100);
      clr;
      foreach (rows[i]) bus(rows[i].a, rows[i].act, rows[i].n);
      wr(REG_TR_SEL, 32'h0);
      rd(REG_TR_ADDR, 32'h1100);
      rd(REG_TR_DATA, 32'h1_1100);
      rd(REG_TR_COUNT, 32'h2);
      rd(REG_STATUS, 32'h10);
      wr(REG_TR_SEL, 32'h1);
      rd(REG_TR_COUNT, 32'h1);
      $display("transition test done");
      wr(REG_CTRL, 32'hF3);
      wr(REG_AC1G1_LO, 32'h1400);
      wr(REG_AC1G1_HI, 32'h1500);
      clr;
      bus(24'h0013FF, 3'h2, 16'h0);
      bus(24'h001400, 3'h6, 16'h1);
      bus(24'h001500, 3'h6, 16'h2);
      bus(24'h001501, 3'h2, 16'h2);
      rd(REG_TR_COUNT, 32'h2);
      wr(REG_TR_SEL, 32'h0);
      rd(REG_TR_DATA, 32'h1501);
      wr(REG_CTRL, 32'h51);
      bus(24'h001400, 3'h6, 16'h2);
      wr(REG_CTRL, 32'h55);
      rd(REG_COUNT, 32'h0);
      rd(REG_CTRL, 32'h51);
      clr;
      rd(REG_COUNT, 32'h0);
      $display("range test done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_STATUS, 32'h0);
      $display("mid-run reset test done");
      test_done;
   end
endmodule : test_event_occurrence_counter
`default_nettype wire
